// ---- hw/csp_regs.svh ----
`ifndef CSP_REGS_SVH
`define CSP_REGS_SVH

// register indices; byte address on the bus is four times the index
`define CSP_IDX_CLKCTL 8'h8e
`define CSP_IDX_GPORT1 8'h90
`define CSP_IDX_CTL_A 8'h92
`define CSP_IDX_CTL_B 8'h93
`define CSP_IDX_B0_LO 8'h94
`define CSP_IDX_B0_HI 8'h95
`define CSP_IDX_B1_LO 8'h96
`define CSP_IDX_B1_HI 8'h97
`define CSP_IDX_B2_LO 8'ha0
`define CSP_IDX_B2_HI 8'ha1
`define CSP_IDX_B3_LO 8'ha2
`define CSP_IDX_B3_HI 8'ha3
`define CSP_IDX_CSPORT 8'ha4
`define CSP_IDX_GPORT1_LATCH 8'ha6
`define CSP_IDX_CSPORT_LATCH 8'ha7

// field layout
`define CSP_PIN_FLD_W 4
`define CSP_STRETCH_LSB 0
`define CSP_STRETCH_W 3

// reset values
`define CSP_RST_GPORT1 8'hff
`define CSP_RST_CSPORT 4'hf
`define CSP_RST_CTL 8'h00
`define CSP_RST_BASE 16'h0000
`define CSP_RST_STRETCH 3'h1

// timing, in clocks and machine cycles
`define CSP_MC_CLKS 6'h04
`define CSP_BASE_MC 6'h02
`define CSP_ONCHIP_MC 6'h02

`endif

// ---- hw/csp_pkg.sv ----
package csp_pkg;

	typedef enum logic [1:0] {
		CSP_FUN_GPIO = 2'b00,
		CSP_FUN_RD = 2'b01,
		CSP_FUN_WR = 2'b10,
		CSP_FUN_RDWR = 2'b11
	} csp_fun_type;

	typedef enum logic [1:0] {
		CSP_CMP_16 = 2'b00,
		CSP_CMP_15 = 2'b01,
		CSP_CMP_14 = 2'b10,
		CSP_CMP_8 = 2'b11
	} csp_cmp_type;

	typedef struct packed {
		csp_fun_type fun;
		csp_cmp_type cmp;
	} csp_pin_cfg_type;

	typedef struct packed {
		logic we;
		logic onchip;
		logic [15:0] addr;
	} csp_xmove_type;

	typedef enum logic [1:0] {
		CSP_ST_IDLE = 2'b00,
		CSP_ST_SETUP = 2'b01,
		CSP_ST_STROBE = 2'b10,
		CSP_ST_HOLD = 2'b11
	} csp_state_type;

endpackage

// ---- hw/csp_top.sv ----
// Overview of operation
// - function 00: pin is plain port I/O
// - function 01: read chip-select strobe
// - function 10: write chip-select strobe
// - function 11: read/write chip-select strobe
// - compare 00: all sixteen address bits
// - compare 01: bits fifteen to one
// - compare 10: bits fifteen to two
// - compare 11: upper address byte only
// - control register packs two pins, function high
// - base address split low/high byte
// - move lasts stretch plus two cycles
// - normal port read returns pin levels
// - read-modify-write read returns output latch
// - strobe stretched; on-chip moves fixed two cycles
// - second pin base high byte register
`timescale 1ns/1ns
`default_nettype none
`include "csp_regs.svh"

module csp_top (
	input wire logic clk_sys_i,
	input wire logic arst_n_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [9:2] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic xmove_req_i,
	input wire csp_pkg::csp_xmove_type xmove_i,
	output logic xmove_busy_o,
	output logic xmove_done_o,
	output logic ext_rd_n_o,
	output logic ext_wr_n_o,
	input wire logic [7:0] gport1_pins_i,
	output logic [7:0] gport1_out_o,
	output logic [7:0] gport1_oe_n_o,
	input wire logic [3:0] csport_pins_i,
	output logic [3:0] csport_out_o,
	output logic [3:0] csport_oe_n_o
);

	function automatic logic addr_match(
		input logic [15:0] addr,
		input logic [15:0] base,
		input csp_pkg::csp_cmp_type cmp
	);
		logic [15:0] mask;
		case (cmp)
			csp_pkg::CSP_CMP_16: mask = 16'hffff;
			csp_pkg::CSP_CMP_15: mask = 16'hfffe;
			csp_pkg::CSP_CMP_14: mask = 16'hfffc;
			default: mask = 16'hff00;
		endcase
		return ((addr ^ base) & mask) == 16'h0000;
	endfunction

	// bus side state
	logic ack_q, ack_d;
	logic [31:0] rdata_q, rdata_d;
	logic [7:0] gport1_latch_q, gport1_latch_d;
	logic [3:0] csport_latch_q, csport_latch_d;
	logic [7:0] ctl_a_q, ctl_a_d;
	logic [7:0] ctl_b_q, ctl_b_d;
	logic [15:0] base_q [4];
	logic [15:0] base_d [4];
	logic [2:0] stretch_q, stretch_d;
	logic wr_en;
	logic [7:0] rd_byte;

	always_comb begin
		ack_d = wb_cyc_i & wb_stb_i & ~ack_q;
		wr_en = ack_d & wb_we_i & wb_sel_i[0];
		gport1_latch_d = gport1_latch_q;
		csport_latch_d = csport_latch_q;
		ctl_a_d = ctl_a_q;
		ctl_b_d = ctl_b_q;
		base_d = base_q;
		stretch_d = stretch_q;
		rd_byte = 8'h00;
		case (wb_adr_i)
			`CSP_IDX_CLKCTL: rd_byte = {5'h00, stretch_q};
			`CSP_IDX_GPORT1: rd_byte = gport1_pins_i;
			`CSP_IDX_CSPORT: rd_byte = {4'h0, csport_pins_i};
			`CSP_IDX_GPORT1_LATCH: rd_byte = gport1_latch_q;
			`CSP_IDX_CSPORT_LATCH: rd_byte = {4'h0, csport_latch_q};
			`CSP_IDX_CTL_A: rd_byte = ctl_a_q;
			`CSP_IDX_CTL_B: rd_byte = ctl_b_q;
			`CSP_IDX_B0_LO: rd_byte = base_q[0][7:0];
			`CSP_IDX_B0_HI: rd_byte = base_q[0][15:8];
			`CSP_IDX_B1_LO: rd_byte = base_q[1][7:0];
			`CSP_IDX_B1_HI: rd_byte = base_q[1][15:8];
			`CSP_IDX_B2_LO: rd_byte = base_q[2][7:0];
			`CSP_IDX_B2_HI: rd_byte = base_q[2][15:8];
			`CSP_IDX_B3_LO: rd_byte = base_q[3][7:0];
			`CSP_IDX_B3_HI: rd_byte = base_q[3][15:8];
			default: rd_byte = 8'h00;
		endcase
		if (wr_en) begin
			case (wb_adr_i)
				`CSP_IDX_CLKCTL: begin
					stretch_d = wb_dat_i[`CSP_STRETCH_LSB +: `CSP_STRETCH_W];
				end
				// writes to port land in the latch, as do the latch views
				`CSP_IDX_GPORT1, `CSP_IDX_GPORT1_LATCH: begin
					gport1_latch_d = wb_dat_i[7:0];
				end
				`CSP_IDX_CSPORT, `CSP_IDX_CSPORT_LATCH: begin
					csport_latch_d = wb_dat_i[3:0];
				end
				`CSP_IDX_CTL_A: begin
					ctl_a_d = wb_dat_i[7:0];
				end
				`CSP_IDX_CTL_B: begin
					ctl_b_d = wb_dat_i[7:0];
				end
				`CSP_IDX_B0_LO: begin
					base_d[0][7:0] = wb_dat_i[7:0];
				end
				`CSP_IDX_B0_HI: begin
					base_d[0][15:8] = wb_dat_i[7:0];
				end
				`CSP_IDX_B1_LO: begin
					base_d[1][7:0] = wb_dat_i[7:0];
				end
				`CSP_IDX_B1_HI: begin
					base_d[1][15:8] = wb_dat_i[7:0];
				end
				`CSP_IDX_B2_LO: begin
					base_d[2][7:0] = wb_dat_i[7:0];
				end
				`CSP_IDX_B2_HI: begin
					base_d[2][15:8] = wb_dat_i[7:0];
				end
				`CSP_IDX_B3_LO: begin
					base_d[3][7:0] = wb_dat_i[7:0];
				end
				`CSP_IDX_B3_HI: begin
					base_d[3][15:8] = wb_dat_i[7:0];
				end
				default: begin
					// unmapped: acked, ignored
				end
			endcase
		end
		rdata_d = (ack_d & ~wb_we_i) ? {24'h000000, rd_byte} : 32'h00000000;
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ack_q <= 1'b0;
			rdata_q <= 32'h00000000;
			gport1_latch_q <= `CSP_RST_GPORT1;
			csport_latch_q <= `CSP_RST_CSPORT;
			ctl_a_q <= `CSP_RST_CTL;
			ctl_b_q <= `CSP_RST_CTL;
			stretch_q <= `CSP_RST_STRETCH;
			for (int i = 0; i < 4; i++) begin
				base_q[i] <= `CSP_RST_BASE;
			end
		end else begin
			ack_q <= ack_d;
			rdata_q <= rdata_d;
			gport1_latch_q <= gport1_latch_d;
			csport_latch_q <= csport_latch_d;
			ctl_a_q <= ctl_a_d;
			ctl_b_q <= ctl_b_d;
			stretch_q <= stretch_d;
			base_q <= base_d;
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdata_q;
	// quasi-bidirectional: drive only a low, release for a one
	assign gport1_out_o = gport1_latch_q;
	assign gport1_oe_n_o = gport1_latch_q;

	// external data move sequencer
	csp_pkg::csp_state_type state_q, state_d;
	csp_pkg::csp_xmove_type req_q, req_d;
	logic [5:0] cnt_q, cnt_d;
	logic done_q, done_d;
	logic ext_rd_n_q, ext_rd_n_d;
	logic ext_wr_n_q, ext_wr_n_d;
	logic [5:0] strobe_mc;
	logic strobe_win_d;

	always_comb begin
		state_d = state_q;
		req_d = req_q;
		cnt_d = cnt_q;
		done_d = 1'b0;
		// strobe phase holds all but the setup cycle
		strobe_mc = req_q.onchip ? (`CSP_ONCHIP_MC - 6'h01)
			: (6'({3'h0, stretch_q}) + `CSP_BASE_MC - 6'h01);
		case (state_q)
			csp_pkg::CSP_ST_IDLE: begin
				if (xmove_req_i) begin
					req_d = xmove_i;
					state_d = csp_pkg::CSP_ST_SETUP;
					cnt_d = `CSP_MC_CLKS - 6'h01;
				end
			end
			csp_pkg::CSP_ST_SETUP: begin
				if (cnt_q == 6'h00) begin
					state_d = csp_pkg::CSP_ST_STROBE;
					cnt_d = 6'(strobe_mc * `CSP_MC_CLKS) - 6'h02;
				end else begin
					cnt_d = cnt_q - 6'h01;
				end
			end
			csp_pkg::CSP_ST_STROBE: begin
				if (cnt_q == 6'h00) begin
					state_d = csp_pkg::CSP_ST_HOLD;
				end else begin
					cnt_d = cnt_q - 6'h01;
				end
			end
			csp_pkg::CSP_ST_HOLD: begin
				state_d = csp_pkg::CSP_ST_IDLE;
				done_d = 1'b1;
			end
			default: begin
				state_d = csp_pkg::CSP_ST_IDLE;
			end
		endcase
		strobe_win_d = (state_d == csp_pkg::CSP_ST_STROBE) & ~req_d.onchip;
		ext_rd_n_d = ~(strobe_win_d & ~req_d.we);
		ext_wr_n_d = ~(strobe_win_d & req_d.we);
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_q <= csp_pkg::CSP_ST_IDLE;
			req_q <= '0;
			cnt_q <= 6'h00;
			done_q <= 1'b0;
			ext_rd_n_q <= 1'b1;
			ext_wr_n_q <= 1'b1;
		end else begin
			state_q <= state_d;
			req_q <= req_d;
			cnt_q <= cnt_d;
			done_q <= done_d;
			ext_rd_n_q <= ext_rd_n_d;
			ext_wr_n_q <= ext_wr_n_d;
		end
	end

	assign xmove_busy_o = state_q != csp_pkg::CSP_ST_IDLE;
	assign xmove_done_o = done_q;
	assign ext_rd_n_o = ext_rd_n_q;
	assign ext_wr_n_o = ext_wr_n_q;

	// chip-select pins
	logic [15:0] ctl_all;
	csp_pkg::csp_pin_cfg_type cfg [4];
	logic [3:0] cs_hit;
	logic [3:0] pin_out_q, pin_out_d;
	logic [3:0] pin_oe_n_q, pin_oe_n_d;

	assign ctl_all = {ctl_b_q, ctl_a_q};

	for (genvar i = 0; i < 4; i++) begin : g_pin
		assign cfg[i] = csp_pkg::csp_pin_cfg_type'(
			ctl_all[i*`CSP_PIN_FLD_W +: `CSP_PIN_FLD_W]);
		assign cs_hit[i] = addr_match(req_d.addr, base_q[i], cfg[i].cmp)
			& ((cfg[i].fun == csp_pkg::CSP_FUN_RD & ~req_d.we)
			| (cfg[i].fun == csp_pkg::CSP_FUN_WR & req_d.we)
			| (cfg[i].fun == csp_pkg::CSP_FUN_RDWR));
	end

	always_comb begin
		for (int i = 0; i < 4; i++) begin
			if (cfg[i].fun == csp_pkg::CSP_FUN_GPIO) begin
				pin_out_d[i] = csport_latch_d[i];
				pin_oe_n_d[i] = csport_latch_d[i];
			end else begin
				pin_out_d[i] = ~(cs_hit[i] & strobe_win_d);
				pin_oe_n_d[i] = 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pin_out_q <= `CSP_RST_CSPORT;
			pin_oe_n_q <= `CSP_RST_CSPORT;
		end else begin
			pin_out_q <= pin_out_d;
			pin_oe_n_q <= pin_oe_n_d;
		end
	end

	assign csport_out_o = pin_out_q;
	assign csport_oe_n_o = pin_oe_n_q;

endmodule // csp_top

`default_nettype wire

// ---- verif/csp_top_checker.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "csp_regs.svh"
module csp_top_checker (
	input wire logic clk_sys_i,
	input wire logic arst_n_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [9:2] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic xmove_req_i,
	input wire csp_pkg::csp_xmove_type xmove_i,
	input wire logic xmove_busy_o,
	input wire logic xmove_done_o,
	input wire logic ext_rd_n_o,
	input wire logic ext_wr_n_o,
	input wire logic [7:0] gport1_out_o,
	input wire logic [7:0] gport1_oe_n_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!arst_n_i);
	sequence s_take;
		xmove_req_i && !xmove_busy_o;
	endsequence
	sequence s_take_onchip;
		s_take ##0 xmove_i.onchip;
	endsequence
	a_ack_follows: assert property (
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("register access not acked");
	a_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data outside ack");
	a_onchip_fixed: assert property (s_take_onchip |-> ##9 xmove_done_o)
		else $error("on-chip move length wrong");
	a_onchip_quiet: assert property (
		s_take_onchip |=> (ext_rd_n_o && ext_wr_n_o)[*8])
		else $error("strobe on on-chip move");
	a_setup_quiet: assert property (
		$rose(xmove_busy_o) |-> (ext_rd_n_o && ext_wr_n_o)[*4])
		else $error("strobe during setup");
	a_strobe_busy: assert property (
		!(ext_rd_n_o && ext_wr_n_o)
		|-> xmove_busy_o && (ext_rd_n_o || ext_wr_n_o))
		else $error("strobe outside move");
	a_hold_done: assert property (
		$rose(ext_rd_n_o) || $rose(ext_wr_n_o) |=> xmove_done_o)
		else $error("no done after hold");
	a_gport_drive: assert property (
		wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == `CSP_IDX_GPORT1
		|-> gport1_out_o == wb_dat_i[7:0] && gport1_oe_n_o == wb_dat_i[7:0])
		else $error("port latch misses write");
endmodule // csp_top_checker
bind csp_top csp_top_checker csp_top_checker_i (
	.clk_sys_i(clk_sys_i),
	.arst_n_i(arst_n_i),
	.wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i),
	.wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i),
	.wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o),
	.xmove_req_i(xmove_req_i),
	.xmove_i(xmove_i),
	.xmove_busy_o(xmove_busy_o),
	.xmove_done_o(xmove_done_o),
	.ext_rd_n_o(ext_rd_n_o),
	.ext_wr_n_o(ext_wr_n_o),
	.gport1_out_o(gport1_out_o),
	.gport1_oe_n_o(gport1_oe_n_o)
);
`default_nettype wire

// ---- verif/csp_ext_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module csp_ext_model (
	input wire logic clk_sys_i,
	input wire logic [7:0] pull_low_i,
	input wire logic [7:0] gport1_out_i,
	input wire logic [7:0] gport1_oe_n_i,
	input wire logic [3:0] csport_out_i,
	input wire logic [3:0] csport_oe_n_i,
	input wire logic ext_rd_n_i,
	input wire logic ext_wr_n_i,
	output logic [7:0] gport1_pins_o,
	output logic [3:0] csport_pins_o,
	output logic hit_o
);
	// released lines go to the pull-up; a part may hold one low
	assign gport1_pins_o = (gport1_oe_n_i | gport1_out_i) & ~pull_low_i;
	assign csport_pins_o = csport_oe_n_i | csport_out_i;
	always_ff @(posedge clk_sys_i) begin
		hit_o <= !(ext_rd_n_i && ext_wr_n_i) && !csport_out_i[0];
	end
endmodule // csp_ext_model
`default_nettype wire

// ---- verif/chip_select_port_decoder_test.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "csp_regs.svh"
module chip_select_port_decoder_test;
	logic clk_sys_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [9:2] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'hf;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic xmove_req_i = 1'b0;
	csp_pkg::csp_xmove_type xmove_i = '0;
	logic xmove_busy_o, xmove_done_o, ext_rd_n_o, ext_wr_n_o, hit;
	logic [7:0] gport1_pins_i, gport1_out_o, gport1_oe_n_o;
	logic [3:0] csport_pins_i, csport_out_o, csport_oe_n_o;
	logic [7:0] pull_low = 8'h00;
	logic [31:0] rd;
	int n_errors = 0;
	int num_checks = 0;
	int n, s, c, h, p;
	csp_top csp_top_i (
		.clk_sys_i(clk_sys_i),
		.arst_n_i(arst_n_i),
		.wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o),
		.xmove_req_i(xmove_req_i),
		.xmove_i(xmove_i),
		.xmove_busy_o(xmove_busy_o),
		.xmove_done_o(xmove_done_o),
		.ext_rd_n_o(ext_rd_n_o),
		.ext_wr_n_o(ext_wr_n_o),
		.gport1_pins_i(gport1_pins_i),
		.gport1_out_o(gport1_out_o),
		.gport1_oe_n_o(gport1_oe_n_o),
		.csport_pins_i(csport_pins_i),
		.csport_out_o(csport_out_o),
		.csport_oe_n_o(csport_oe_n_o)
	);
	csp_ext_model csp_ext_model_i (
		.clk_sys_i(clk_sys_i),
		.pull_low_i(pull_low),
		.gport1_out_i(gport1_out_o),
		.gport1_oe_n_i(gport1_oe_n_o),
		.csport_out_i(csport_out_o),
		.csport_oe_n_i(csport_oe_n_o),
		.ext_rd_n_i(ext_rd_n_o),
		.ext_wr_n_i(ext_wr_n_o),
		.gport1_pins_o(gport1_pins_i),
		.csport_pins_o(csport_pins_i),
		.hit_o(hit)
	);
	initial begin
		forever #2 clk_sys_i = ~clk_sys_i;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wb(input logic we, input logic [7:0] idx,
		input logic [7:0] d);
		@(posedge clk_sys_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= idx;
		wb_dat_i <= {24'h0, d};
		@(posedge clk_sys_i);
		while (wb_ack_o !== 1'b1) @(posedge clk_sys_i);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	// counts clocks to done, strobe clocks, clocks with both selects low
	task automatic mv(input logic we, input logic onc, input logic [15:0] a);
		@(posedge clk_sys_i);
		xmove_req_i <= 1'b1;
		xmove_i <= '{we, onc, a};
		@(posedge clk_sys_i);
		xmove_req_i <= 1'b0;
		n = 1;
		s = 0;
		c = 0;
		h = 0;
		p = 0;
		#1;
		while (xmove_done_o !== 1'b1 && n < 60) begin
			s += (ext_rd_n_o === 1'b1 && ext_wr_n_o === 1'b1) ? 0 : 1;
			c += (csport_out_o[1:0] === 2'b00) ? 1 : 0;
			p += (csport_out_o[2] === 1'b0) ? 1 : 0;
			h += (hit === 1'b1) ? 1 : 0;
			@(posedge clk_sys_i);
			#1;
			n++;
		end
	endtask
	task automatic t_reset();
		wb(0, `CSP_IDX_CLKCTL, 8'h00);
		chk(rd, 32'h1);
		wb(0, `CSP_IDX_CTL_B, 8'h00);
		chk(rd, 32'h0);
		wb(0, `CSP_IDX_CSPORT_LATCH, 8'h00);
		chk(rd, 32'hf);
	endtask
	task automatic t_regs();
		logic [7:0] idx[8] = '{`CSP_IDX_B0_LO, `CSP_IDX_B0_HI, `CSP_IDX_B1_LO,
			`CSP_IDX_B1_HI, `CSP_IDX_B2_LO, `CSP_IDX_B2_HI, `CSP_IDX_B3_LO,
			`CSP_IDX_B3_HI};
		// all writes first so aliased registers show up
		foreach (idx[i]) wb(1, idx[i], idx[i] ^ 8'h5a);
		foreach (idx[i]) begin
			wb(0, idx[i], 8'h00);
			chk(rd, {24'h0, idx[i] ^ 8'h5a});
		end
		wb(1, 8'h80, 8'h77);
		wb(0, 8'h80, 8'h00);
		chk(rd, 32'h0);
	endtask
	task automatic t_port();
		pull_low <= 8'h81;
		wb(1, `CSP_IDX_GPORT1, 8'h0f);
		wb(0, `CSP_IDX_GPORT1, 8'h00);
		chk(rd, 32'h0e);
		wb(0, `CSP_IDX_GPORT1_LATCH, 8'h00);
		chk(rd, 32'h0f);
		wb(1, `CSP_IDX_CSPORT, 8'h05);
		wb(0, `CSP_IDX_CSPORT, 8'h00);
		chk(rd, 32'h5);
	endtask
	task automatic t_cs();
		logic [15:0] adr[4] = '{16'h1234, 16'h1235, 16'h1236, 16'h12ff};
		int e;
		wb(1, `CSP_IDX_B0_LO, 8'h34);
		wb(1, `CSP_IDX_B0_HI, 8'h12);
		wb(1, `CSP_IDX_B1_LO, 8'h34);
		wb(1, `CSP_IDX_B1_HI, 8'h12);
		for (int f = 0; f < 4; f++) begin
			for (int m = 0; m < 4; m++) begin
				wb(1, `CSP_IDX_CTL_A, {2{f[1:0], m[1:0]}});
				for (int j = 0; j < 4; j++) begin
					for (int w = 0; w < 2; w++) begin
						mv(w[0], 1'b0, adr[j]);
						e = (j <= m && (w == 1 ? f[1] : f[0])) ? 7 : 0;
						chk(c, e);
					end
				end
				chk(csport_oe_n_o[1:0], (f == 0) ? 2'h1 : 2'h0);
			end
		end
	endtask
	task automatic t_stretch();
		for (int st = 0; st < 8; st++) begin
			wb(1, `CSP_IDX_CLKCTL, st[7:0]);
			mv(1'b1, 1'b0, 16'h1200);
			chk(n, 4 * st + 9);
			chk(s, 4 * st + 3);
			chk(c, 4 * st + 3);
			chk(h, 4 * st + 3);
		end
		mv(1'b0, 1'b1, 16'h1234);
		chk(n, 9);
		chk(s + c, 0);
		// pin two: read strobe, upper byte compare
		wb(1, `CSP_IDX_CTL_B, 8'h07);
		mv(1'b0, 1'b0, 16'hfbcd);
		chk(p, 4 * 7 + 3);
	endtask
	task automatic wrap_up();
		if (n_errors == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge clk_sys_i);
		arst_n_i <= 1'b1;
		t_reset();
		t_regs();
		t_port();
		t_cs();
		t_stretch();
		wrap_up();
	end
	initial begin
		repeat (20000) @(posedge clk_sys_i);
		n_errors++;
		wrap_up();
	end
endmodule // chip_select_port_decoder_test
`default_nettype wire
